// ---- hw/lfs_access.sv ----
// lock, fuse and information table access logic
`timescale 1ns/1ps
`default_nettype none
module lfs_access (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic CTL_WR,
    input wire logic [7:0] CTL_WDATA,
    output logic [7:0] CTL_RDATA,
    input wire logic LOAD_INSTR,
    input wire logic STORE_INSTR,
    input wire logic [15:0] PTR,
    output logic LOAD_SPECIAL,
    output logic [7:0] LOAD_DATA,
    output logic STORE_ALLOWED,
    input wire logic EEPROM_BUSY,
    input wire logic PROG_MODE,
    input wire logic PROG_SERIAL,
    input wire logic PROG_ENTER,
    input wire logic PROG_EXIT,
    input wire logic PROG_LOCK_WR,
    input wire logic PROG_FUSE_WR,
    input wire logic [1:0] PROG_FUSE_SEL,
    input wire logic [7:0] PROG_WDATA,
    input wire logic PROG_CHIP_ERASE,
    input wire logic PROG_TBL_RD,
    input wire logic [4:0] PROG_TBL_WORD,
    input wire logic PROG_TBL_HIGH,
    output logic [7:0] PROG_RDATA,
    input wire logic TBL_WR,
    input wire logic [5:0] TBL_WADDR,
    input wire logic [7:0] TBL_WDATA,
    output logic [7:0] FAST_OSC_CAL,
    output logic [7:0] SLOW_OSC_CAL,
    output logic [1:0] PROT_LEVEL,
    output logic [7:0] FUSE_EXT_ACTIVE,
    output logic [7:0] FUSE_HIGH_ACTIVE,
    output logic [7:0] FUSE_LOW_ACTIVE,
    output logic EEPROM_PRESERVE,
    output logic SERIAL_PROG_ALLOWED,
    output logic RESET_PIN_REPURPOSED
);
    // nonvolatile cells and their latched copies
    logic [7:0] lock_r;
    logic [7:0] fuse_ext_r, fuse_high_r, fuse_low_r;
    logic [7:0] lat_ext_r, lat_high_r, lat_low_r;
    logic [2:0] ctl_bits_r; // {sig, flr, store}
    logic [2:0] win_cnt_r;
    logic [1:0] cal_step_r;
    logic [7:0] fast_cal_r, slow_cal_r;
    logic [7:0] load_data_r, prog_rdata_r;
    logic [5:0] tbl_addr;
    logic [7:0] tbl_data;
    logic fuse_frozen;
    logic [1:0] lock_nxt;
    lfs_pkg::lfs_prot_t prot;

    // lock bits to protection level
    function automatic lfs_pkg::lfs_prot_t level_of(input logic [1:0] lb);
        case (lb)
            2'b11: level_of = lfs_pkg::LFS_PROT_NONE;
            2'b10: level_of = lfs_pkg::LFS_PROT_WRITE;
            default: level_of = lfs_pkg::LFS_PROT_FULL;
        endcase
    endfunction

    assign prot = level_of({lock_r[lfs_pkg::LOCK_SECOND_POS], lock_r[lfs_pkg::LOCK_FIRST_POS]});
    assign PROT_LEVEL = prot;
    assign fuse_frozen = ~lock_r[lfs_pkg::LOCK_FIRST_POS];

    // only raise protection; otherwise go to maximum
    always_comb begin
        if (level_of(PROG_WDATA[1:0]) > prot) begin
            lock_nxt = PROG_WDATA[1:0] & lock_r[1:0];
        end else begin
            lock_nxt = 2'b00;
        end
    end

    // lock cell, chip erase restores it
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            lock_r <= lfs_pkg::LOCK_RESET;
        end else if (PROG_MODE && PROG_CHIP_ERASE) begin
            lock_r <= lfs_pkg::LOCK_RESET;
        end else if (PROG_MODE && PROG_LOCK_WR) begin
            lock_r <= {6'h3F, lock_nxt};
        end
    end

    // fuse cells: frozen while the first lock bit is programmed, untouched by chip erase
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            fuse_ext_r <= lfs_pkg::FUSE_EXT_RESET;
            fuse_high_r <= lfs_pkg::FUSE_HIGH_RESET;
            fuse_low_r <= lfs_pkg::FUSE_LOW_RESET;
        end else if (PROG_MODE && PROG_FUSE_WR && !fuse_frozen) begin
            case (PROG_FUSE_SEL)
                lfs_pkg::ADDR_FUSE_LOW[1:0]: fuse_low_r <= PROG_WDATA;
                lfs_pkg::ADDR_FUSE_EXT[1:0]: fuse_ext_r <= PROG_WDATA;
                lfs_pkg::ADDR_FUSE_HIGH[1:0]: begin
                    // serial port cannot change serial enable
                    if (PROG_SERIAL) begin
                        fuse_high_r <= {PROG_WDATA[7:6], fuse_high_r[5], PROG_WDATA[4:0]};
                    end else begin
                        fuse_high_r <= PROG_WDATA;
                    end
                end
                default: ;
            endcase
        end
    end

    // latch fuses every cycle outside programming mode and on programming entry/exit
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            lat_ext_r <= lfs_pkg::FUSE_EXT_RESET;
            lat_high_r <= lfs_pkg::FUSE_HIGH_RESET;
            lat_low_r <= lfs_pkg::FUSE_LOW_RESET;
        end else if (PROG_ENTER || PROG_EXIT || !PROG_MODE) begin
            lat_ext_r <= fuse_ext_r;
            lat_high_r <= fuse_high_r;
            lat_low_r <= fuse_low_r;
        end
    end
    assign FUSE_EXT_ACTIVE = lat_ext_r;
    assign FUSE_HIGH_ACTIVE = lat_high_r;
    assign FUSE_LOW_ACTIVE = lat_low_r;
    // preserve fuse taken live from the cell
    assign EEPROM_PRESERVE = ~fuse_high_r[lfs_pkg::FHIGH_EEKEEP_POS];
    // reset or debug fuse repurposes pin, blocks serial programming
    assign RESET_PIN_REPURPOSED = ~lat_high_r[lfs_pkg::FHIGH_RSTDIS_POS]
        | ~lat_high_r[lfs_pkg::FHIGH_DBG_POS];
    assign SERIAL_PROG_ALLOWED = ~lat_high_r[lfs_pkg::FHIGH_SERIAL_POS] & ~RESET_PIN_REPURPOSED;

    // control register bits and window timer
    // the window counter starts at zero on the accepted write and counts every
    // later cycle without a control write while any control bit stays set
    // a read request (signature or fuse/lock) closes after three cycles and a
    // plain store request after four, so a late load behaves as a normal load
    // any special load or store ends the sequence at once
    // writes during an eeprom write are dropped whole, so bits already set and the window count are kept
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctl_bits_r <= 3'h0;
            win_cnt_r <= 3'h0;
        end else if (CTL_WR) begin
            if (!EEPROM_BUSY) begin
                ctl_bits_r <= {CTL_WDATA[lfs_pkg::CTL_SIG_POS], CTL_WDATA[lfs_pkg::CTL_FLR_POS],
                    CTL_WDATA[lfs_pkg::CTL_STORE_POS]};
                win_cnt_r <= 3'h0;
            end
        end else if (ctl_bits_r != 3'h0) begin
            // clear on completed access or expired window
            if (LOAD_SPECIAL || STORE_INSTR) begin
                ctl_bits_r <= 3'h0;
            end else if ((ctl_bits_r[2:1] != 2'b00 && win_cnt_r + 3'h1 >= lfs_pkg::LOAD_WINDOW)
                || win_cnt_r + 3'h1 >= lfs_pkg::STORE_WINDOW) begin
                ctl_bits_r <= 3'h0;
            end
            win_cnt_r <= win_cnt_r + 3'h1;
        end
    end
    assign CTL_RDATA = {2'b00, ctl_bits_r[2], 1'b0, ctl_bits_r[1], 2'b00, ctl_bits_r[0]};

    // special load while read bit and store bit are set
    // a busy eeprom also blocks a read already armed
    assign LOAD_SPECIAL = LOAD_INSTR && ctl_bits_r[0] && (ctl_bits_r[2] || ctl_bits_r[1])
        && win_cnt_r < lfs_pkg::LOAD_WINDOW && !EEPROM_BUSY;
    // store allowed only with self-program fuse programmed, not during eeprom
    assign STORE_ALLOWED = STORE_INSTR && ctl_bits_r[0] && !EEPROM_BUSY
        && !lat_ext_r[lfs_pkg::FEXT_SELFPRG_POS];

    // core uses byte address, programmer word plus half select
    assign tbl_addr = (cal_step_r != 2'h0) ? ((cal_step_r == 2'h1) ? lfs_pkg::TBL_FAST_CAL
        : lfs_pkg::TBL_SLOW_CAL) : (PROG_TBL_RD ? {PROG_TBL_WORD, PROG_TBL_HIGH} : PTR[5:0]);

    lfs_info_table u_table (
        .clk(CLOCK),
        .srst(SRST),
        .wr_en(TBL_WR),
        .wr_addr(TBL_WADDR),
        .wr_data(TBL_WDATA),
        .rd_addr(tbl_addr),
        .rd_data(tbl_data)
    );

    // copy calibration bytes while reset is asserted
    // step 1 copies the fast byte, step 2 the slow byte; any other step restarts,
    // so an unknown step at power-up still reaches the copy within the reset
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            case (cal_step_r)
                2'h0: cal_step_r <= 2'h1;
                2'h1: cal_step_r <= 2'h2;
                default: cal_step_r <= 2'h0;
            endcase
            if (cal_step_r == 2'h1) begin
                fast_cal_r <= tbl_data;
            end
            if (cal_step_r == 2'h2) begin
                slow_cal_r <= tbl_data;
            end
        end else begin
            cal_step_r <= 2'h0;
        end
    end
    assign FAST_OSC_CAL = fast_cal_r;
    assign SLOW_OSC_CAL = slow_cal_r;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            load_data_r <= 8'h00;
        end else if (LOAD_SPECIAL) begin
            if (ctl_bits_r[2]) begin
                load_data_r <= tbl_data;
            end else begin
                case (PTR)
                    lfs_pkg::ADDR_FUSE_LOW: load_data_r <= fuse_low_r;
                    lfs_pkg::ADDR_LOCK: load_data_r <= lock_r;
                    lfs_pkg::ADDR_FUSE_EXT: load_data_r <= fuse_ext_r;
                    lfs_pkg::ADDR_FUSE_HIGH: load_data_r <= fuse_high_r;
                    default: load_data_r <= 8'hFF;
                endcase
            end
        end
    end
    assign LOAD_DATA = load_data_r;

    // programmer table read works in any lock state
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            prog_rdata_r <= 8'h00;
        end else if (PROG_TBL_RD) begin
            prog_rdata_r <= tbl_data;
        end
    end
    assign PROG_RDATA = prog_rdata_r;
endmodule
`default_nettype wire

// ---- hw/lfs_pkg.sv ----
// constants for the lock, fuse and information table access block
package lfs_pkg;
    // fuse/lock read pointer values
    localparam logic [15:0] ADDR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] ADDR_LOCK = 16'h0001;
    localparam logic [15:0] ADDR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] ADDR_FUSE_HIGH = 16'h0003;
    // information table byte addresses
    localparam logic [5:0] TBL_FAST_CAL = 6'h01;
    localparam logic [5:0] TBL_SLOW_CAL = 6'h07;
    localparam logic [5:0] TBL_SERIAL_FIRST = 6'h0E;
    localparam logic [5:0] TBL_SERIAL_LAST = 6'h17;
    localparam logic [5:0] TBL_TEMP_GAIN = 6'h2C;
    localparam logic [5:0] TBL_TEMP_OFFSET = 6'h2D;
    localparam int TBL_DEPTH = 64;
    // control register bit positions
    localparam int CTL_SIG_POS = 5;
    localparam int CTL_FLR_POS = 3;
    localparam int CTL_STORE_POS = 0;
    // lock byte fields
    localparam int LOCK_SECOND_POS = 1;
    localparam int LOCK_FIRST_POS = 0;
    // reset values of the nonvolatile bytes (1 = unprogrammed)
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
    localparam logic [7:0] FUSE_HIGH_RESET = 8'hDF;
    localparam logic [7:0] FUSE_LOW_RESET = 8'h62; // div8 and sut programmed, fast osc source
    // fuse field positions
    localparam int FEXT_SELFPRG_POS = 0;
    localparam int FHIGH_RSTDIS_POS = 7;
    localparam int FHIGH_DBG_POS = 6;
    localparam int FHIGH_SERIAL_POS = 5;
    localparam int FHIGH_WDOG_POS = 4;
    localparam int FHIGH_EEKEEP_POS = 3;
    localparam int FLOW_DIV8_POS = 7;
    localparam int FLOW_CLOCK_OUTPUT_FUSE_POS = 6;
    localparam int FLOW_SUT_POS = 4;
    // timed sequence windows in cycles
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    // protection levels
    typedef enum logic [1:0] {LFS_PROT_NONE, LFS_PROT_WRITE, LFS_PROT_FULL} lfs_prot_t;
endpackage

// ---- hw/lfs_info_table.sv ----
// device information table storage with byte read port
`timescale 1ns/1ps
`default_nettype none
module lfs_info_table #(
    parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C  // arbitrary identity value
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_r [0:lfs_pkg::TBL_DEPTH-1];
    // factory write port; signature bytes are hard and never erased
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end
    // identity code is readable in every lock state
    always_comb begin
        case (rd_addr)
            6'h00: rd_data = SIG_BYTE0;
            6'h02: rd_data = SIG_BYTE1;
            6'h04: rd_data = SIG_BYTE2;
            default: rd_data = mem_r[rd_addr];
        endcase
    end
endmodule
`default_nettype wire

// ---- test/lfs_access_checker.sv ----
// assertion checker for the lock, fuse and table access block
`timescale 1ns/1ps
`default_nettype none
module lfs_access_checker (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic CTL_WR,
    input wire logic [7:0] CTL_WDATA,
    input wire logic [7:0] CTL_RDATA,
    input wire logic LOAD_INSTR,
    input wire logic [15:0] PTR,
    input wire logic SERIAL_PROG_ALLOWED,
    input wire logic LOAD_SPECIAL,
    input wire logic [7:0] LOAD_DATA,
    input wire logic STORE_ALLOWED,
    input wire logic EEPROM_BUSY,
    input wire logic PROG_CHIP_ERASE,
    input wire logic [1:0] PROT_LEVEL,
    input wire logic [7:0] FUSE_EXT_ACTIVE,
    input wire logic [7:0] FUSE_HIGH_ACTIVE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // accepted fuse/lock read request on the control register
    wire logic fl_wr = CTL_WR && CTL_WDATA == 8'h09 && !EEPROM_BUSY;
    // timed sequence, gating and protection checks
    chk_load_special: assert property (
        fl_wr ##1 LOAD_INSTR |-> LOAD_SPECIAL) else $error("load not special");
    chk_load_clears: assert property (
        fl_wr ##1 LOAD_INSTR |=> CTL_RDATA == 8'h00) else $error("bits kept after read");
    chk_window_expiry: assert property (
        fl_wr ##1 (!LOAD_INSTR && !CTL_WR)[*4] |=> CTL_RDATA == 8'h00 && !LOAD_SPECIAL)
        else $error("window did not close");
    chk_busy_refuse: assert property (
        CTL_WR && EEPROM_BUSY && CTL_RDATA == 8'h00 |=> CTL_RDATA == 8'h00)
        else $error("control written while busy");
    chk_lock_unused: assert property (
        fl_wr ##1 (LOAD_INSTR && PTR == 16'h0001) |=> LOAD_DATA[7:2] == 6'h3F)
        else $error("lock byte upper bits");
    chk_store_gate: assert property (
        STORE_ALLOWED |-> !FUSE_EXT_ACTIVE[0] && !EEPROM_BUSY) else $error("store not gated");
    chk_serial_gate: assert property (
        SERIAL_PROG_ALLOWED |-> FUSE_HIGH_ACTIVE[7] && FUSE_HIGH_ACTIVE[6]
        && !FUSE_HIGH_ACTIVE[5]) else $error("serial allowed with pin repurposed");
    chk_prot_monotone: assert property (
        PROT_LEVEL < $past(PROT_LEVEL) |-> $past(PROG_CHIP_ERASE))
        else $error("protection lowered without erase");
endmodule
`default_nettype wire

// ---- test/lfs_core_model.sv ----
// behavioural processor core issuing timed control writes, loads and stores
`timescale 1ns/1ps
`default_nettype none
module lfs_core_model (
    input wire logic CLOCK,
    output logic CTL_WR,
    output logic [7:0] CTL_WDATA,
    output logic LOAD_INSTR,
    output logic STORE_INSTR,
    output logic [15:0] PTR,
    input wire logic LOAD_SPECIAL,
    input wire logic [7:0] LOAD_DATA,
    input wire logic STORE_ALLOWED
);
    // idle core drives nothing active
    initial begin
        CTL_WR = 1'b0;
        CTL_WDATA = 8'h00;
        LOAD_INSTR = 1'b0;
        STORE_INSTR = 1'b0;
        PTR = 16'h0000;
    end
    // control write, idle gap, then one load or store sampled in its own cycle
    // gap below three keeps the load inside the window
    task automatic access(input logic [7:0] ctl, input logic [15:0] p, input int gap,
                          input bit store, output logic sp, output logic [7:0] d);
        CTL_WDATA = ctl;
        PTR = p;
        CTL_WR = 1'b1;
        @(posedge CLOCK);
        #1;
        CTL_WR = 1'b0;
        CTL_WDATA = ~ctl; // released data does not keep its value
        repeat (gap) @(posedge CLOCK);
        if (gap > 0) #1;
        if (store) STORE_INSTR = 1'b1;
        else LOAD_INSTR = 1'b1;
        #1;
        sp = store ? STORE_ALLOWED : LOAD_SPECIAL;
        @(posedge CLOCK);
        #1;
        LOAD_INSTR = 1'b0;
        STORE_INSTR = 1'b0;
        d = LOAD_DATA;
        PTR = ~p;
    endtask
endmodule
`default_nettype wire

// ---- test/lfs_access_tb.sv ----
// self-checking testbench for the lock, fuse and table access block
`timescale 1ns/1ps
`default_nettype none
module lfs_access_tb;
    logic CLOCK = 1'b0, SRST = 1'b1, EEPROM_BUSY = 1'b0, PROG_MODE = 1'b0, PROG_SERIAL = 1'b0;
    logic PROG_ENTER = 1'b0, PROG_EXIT = 1'b0, PROG_LOCK_WR = 1'b0, PROG_FUSE_WR = 1'b0;
    logic PROG_CHIP_ERASE = 1'b0, PROG_TBL_RD = 1'b0, PROG_TBL_HIGH = 1'b0, TBL_WR = 1'b0;
    logic [1:0] PROG_FUSE_SEL = 2'h0;
    logic [7:0] PROG_WDATA = 8'h00, TBL_WDATA = 8'h00;
    logic [4:0] PROG_TBL_WORD = 5'h00;
    logic [5:0] TBL_WADDR = 6'h00;
    wire logic CTL_WR, LOAD_INSTR, STORE_INSTR, LOAD_SPECIAL, STORE_ALLOWED, EEPROM_PRESERVE;
    wire logic SERIAL_PROG_ALLOWED, RESET_PIN_REPURPOSED;
    wire logic [15:0] PTR;
    wire logic [1:0] PROT_LEVEL;
    wire logic [7:0] CTL_WDATA, CTL_RDATA, LOAD_DATA, PROG_RDATA, FAST_OSC_CAL, SLOW_OSC_CAL;
    wire logic [7:0] FUSE_EXT_ACTIVE, FUSE_HIGH_ACTIVE, FUSE_LOW_ACTIVE;
    int n_mismatch = 0;
    int tests_run = 0;
    logic sp;
    logic [7:0] d;
    logic [7:0] fuse_exp [4] = '{8'h62, 8'hFF, 8'hFF, 8'hDF};
    lfs_access lfs_access_i (.CLOCK, .SRST, .CTL_WR, .CTL_WDATA, .CTL_RDATA, .LOAD_INSTR,
        .STORE_INSTR, .PTR, .LOAD_SPECIAL, .LOAD_DATA, .STORE_ALLOWED, .EEPROM_BUSY, .PROG_MODE,
        .PROG_SERIAL, .PROG_ENTER, .PROG_EXIT, .PROG_LOCK_WR, .PROG_FUSE_WR, .PROG_FUSE_SEL,
        .PROG_WDATA, .PROG_CHIP_ERASE, .PROG_TBL_RD, .PROG_TBL_WORD, .PROG_TBL_HIGH, .PROG_RDATA,
        .TBL_WR, .TBL_WADDR, .TBL_WDATA, .FAST_OSC_CAL, .SLOW_OSC_CAL, .PROT_LEVEL,
        .FUSE_EXT_ACTIVE, .FUSE_HIGH_ACTIVE, .FUSE_LOW_ACTIVE, .EEPROM_PRESERVE,
        .SERIAL_PROG_ALLOWED, .RESET_PIN_REPURPOSED);
    lfs_core_model lfs_core_model_i (.CLOCK, .CTL_WR, .CTL_WDATA, .LOAD_INSTR, .STORE_INSTR,
        .PTR, .LOAD_SPECIAL, .LOAD_DATA, .STORE_ALLOWED);
    // 100 MHz clock
    always #5 CLOCK = ~CLOCK;
    // compare, count and report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge CLOCK);
        #1;
    endtask
    // programmer or factory pulse: 0 enter, 1 exit, 2 lock, 3 fuse, 4 erase, 5 table fill
    task automatic pw(input int k, input logic [5:0] a, input logic [7:0] v);
        {PROG_ENTER, PROG_EXIT, PROG_LOCK_WR, PROG_FUSE_WR, PROG_CHIP_ERASE, TBL_WR} = 6'h20 >> k;
        PROG_FUSE_SEL = a[1:0];
        TBL_WADDR = a;
        PROG_WDATA = v;
        TBL_WDATA = v;
        tick();
        {PROG_ENTER, PROG_EXIT, PROG_LOCK_WR, PROG_FUSE_WR, PROG_CHIP_ERASE, TBL_WR} = 6'h00;
        tick();
    endtask
    task automatic do_reset;
        SRST = 1'b1;
        repeat (10) tick();
        SRST = 1'b0;
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset();
        for (int i = 0; i < 4; i++) begin
            lfs_core_model_i.access(8'h09, 16'(i), i % 3, 1'b0, sp, d);
            chk(8'(sp), 8'h01);
            chk(d, fuse_exp[i]);
        end
        lfs_core_model_i.access(8'h01, 16'h0000, 1, 1'b1, sp, d);
        chk(8'(sp), 8'h00);
        lfs_core_model_i.access(8'h09, 16'h0001, 4, 1'b0, sp, d);
        chk(8'(sp), 8'h00);
        EEPROM_BUSY = 1'b1;
        lfs_core_model_i.access(8'h09, 16'h0001, 0, 1'b0, sp, d);
        chk(8'(sp), 8'h00);
        EEPROM_BUSY = 1'b0;
        pw(5, 6'h01, 8'h6B);
        pw(5, 6'h07, 8'h2E);
        pw(5, 6'h2D, 8'h81);
        do_reset();
        chk(FAST_OSC_CAL, 8'h6B);
        chk(SLOW_OSC_CAL, 8'h2E);
        lfs_core_model_i.access(8'h21, 16'h002D, 2, 1'b0, sp, d);
        chk(d, 8'h81);
        PROG_MODE = 1'b1;
        pw(0, 6'h00, 8'h00);
        pw(3, 6'h02, 8'hFE);
        pw(3, 6'h03, 8'hD7);
        chk(FUSE_EXT_ACTIVE, 8'hFF);
        chk(8'(EEPROM_PRESERVE), 8'h01);
        pw(2, 6'h00, 8'hFE);
        chk(8'(PROT_LEVEL), 8'h01);
        PROG_TBL_WORD = 5'h16;
        PROG_TBL_HIGH = 1'b1;
        PROG_TBL_RD = 1'b1;
        tick();
        PROG_TBL_RD = 1'b0;
        chk(PROG_RDATA, 8'h81);
        pw(3, 6'h03, 8'h57);
        pw(2, 6'h00, 8'hFF);
        chk(8'(PROT_LEVEL), 8'h02);
        pw(4, 6'h00, 8'h00);
        chk(8'(PROT_LEVEL), 8'h00);
        PROG_MODE = 1'b0;
        pw(1, 6'h00, 8'h00);
        chk(FUSE_EXT_ACTIVE, 8'hFE);
        chk(FUSE_HIGH_ACTIVE, 8'hD7);
        chk(8'(SERIAL_PROG_ALLOWED), 8'h01);
        lfs_core_model_i.access(8'h01, 16'h0000, 3, 1'b1, sp, d);
        chk(8'(sp), 8'h01);
        close_out();
    end
endmodule
bind lfs_access lfs_access_checker lfs_access_checker_i (.CLOCK, .SRST, .CTL_WR, .CTL_WDATA,
    .CTL_RDATA, .LOAD_INSTR, .PTR, .SERIAL_PROG_ALLOWED, .LOAD_SPECIAL, .LOAD_DATA,
    .STORE_ALLOWED, .EEPROM_BUSY,
    .PROG_CHIP_ERASE, .PROT_LEVEL, .FUSE_EXT_ACTIVE, .FUSE_HIGH_ACTIVE);
`default_nettype wire
